// ===== core/program_sequencer_cfg.svh
// Constants of the program sequencer: widths, reset values, op lengths.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PROGRAM_SEQUENCER_CFG_SVH
`define PROGRAM_SEQUENCER_CFG_SVH

`define PC_W 10
`define PC_RESET 10'h000
`define LEN_W 2
`define LEN_ONE 2'h1
`define RET_LO_W 8
`define RET_HI_W 2
`define RET_HI_LSB 8
`define SP_EMPTY 1'h0
`define SP_FULL 1'h1
`define SYNC_W 2
`define SYNC_RST_N 0
`define SYNC_POC 1
`define SYNC_IDLE 2'h1
`define RET_HI_FILL 2'h0

`endif

// ===== core/program_sequencer_pkg.sv
// Types shared by the program sequencer design files.
// Assumes program_sequencer_cfg.svh is on the include path.
`include "program_sequencer_cfg.svh"

package program_sequencer_pkg;

  typedef enum logic [2:0] {
    op_sequential,
    jump_always_op,
    jump_on_carry_op,
    jump_on_no_carry_op,
    jump_on_flag_op,
    jump_on_no_flag_op,
    subroutine_call_op,
    subroutine_return_op
  } op_kind_t;

  typedef struct packed {
    op_kind_t kind;
    logic [`LEN_W-1:0] length;
    logic [`PC_W-1:0] target;
    logic carry;
    logic status_flag;
  } op_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [`RET_LO_W-1:0] wdata;
  } shared_access_t;

  typedef struct packed {
    logic [`PC_W-1:0] program_counter;
    logic stack_pointer;
    logic [`PC_W-1:0] return_address;
    logic ret_hi_valid;
  } seq_state_t;

endpackage

// ===== core/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the pins are slow levels; each bit is synchronised on its own.
`include "program_sequencer_cfg.svh"

module pin_sync (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [`SYNC_W-1:0] pin_i,
  output logic [`SYNC_W-1:0] level_o
);
  import program_sequencer_pkg::*;

  localparam logic [`SYNC_W-1:0] idle_lvl = `SYNC_IDLE;

  logic [`SYNC_W-1:0] meta_ff;
  logic [`SYNC_W-1:0] level_ff;

  genvar g;
  generate
    for (g = 0; g < `SYNC_W; g++) begin : g_bit
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          meta_ff[g] <= idle_lvl[g];
          level_ff[g] <= idle_lvl[g];
        end else begin
          meta_ff[g] <= pin_i[g];
          level_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  assign level_o = level_ff;
endmodule

// ===== core/return_address_store.sv
// Return address storage; its low byte doubles as the last data word.
// Assumes the caller never writes by call and by data in one cycle.
`include "program_sequencer_cfg.svh"

module return_address_store (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic save_i,
  input wire logic [`PC_W-1:0] save_addr_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic [`RET_LO_W-1:0] data_wdata_i,
  output logic [`PC_W-1:0] ret_addr_o,
  output logic [`RET_LO_W-1:0] data_rdata_o,
  output logic hi_valid_o
);
  import program_sequencer_pkg::*;

  // Contents are never reset: they survive a system reset; only the valid flag is cleared by reset
  logic [`RET_LO_W-1:0] lo_ff;
  logic [`RET_HI_W-1:0] hi_ff;
  logic [`RET_LO_W-1:0] rdata_ff;
  logic hi_valid_ff;

  always_ff @(posedge ref_clk_i) begin
    if (save_i) begin
      lo_ff <= save_addr_i[`RET_LO_W-1:0];
      hi_ff <= save_addr_i[`PC_W-1:`RET_HI_LSB];
    end else if (data_wr_i) begin
      lo_ff <= data_wdata_i;
      hi_ff <= `RET_HI_FILL;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (data_rd_i) begin
      rdata_ff <= lo_ff;
    end
  end

  // Upper bits are trusted only after a call saved them
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hi_valid_ff <= 1'b0;
    end else if (save_i) begin
      hi_valid_ff <= 1'b1;
    end else if (data_wr_i || data_rd_i) begin
      hi_valid_ff <= 1'b0;
    end
  end

  assign ret_addr_o = {hi_ff, lo_ff};
  assign data_rdata_o = rdata_ff;
  assign hi_valid_o = hi_valid_ff;
endmodule

// ===== core/program_sequencer_stack.sv
// Program sequencer: program counter, one-level stack, return address.
// Assumes one op is offered at a time with op_valid_i and taken when
// op_ready_o is high; the reset pin and power-on clear are asynchronous.
`include "program_sequencer_cfg.svh"

module program_sequencer_stack (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic reset_pin_n_i,
  input wire logic power_on_clear_i,
  input wire logic op_valid_i,
  input wire program_sequencer_pkg::op_req_t op_i,
  output logic op_ready_o,
  output logic op_done_o,
  input wire program_sequencer_pkg::shared_access_t shared_data_word_i,
  output logic [`RET_LO_W-1:0] shared_data_word_o,
  output program_sequencer_pkg::seq_state_t seq_state_o,
  output logic system_reset_o,
  output logic reset_pin_o,
  output logic reset_pin_oe_o
);
  import program_sequencer_pkg::*;

  typedef enum logic [1:0] {
    st_held,
    st_run,
    st_fault
  } seq_fsm_t;

  // Decodes whether a branch op redirects the counter
  function automatic logic jump_taken(input op_req_t op);
    case (op.kind)
      jump_always_op: jump_taken = 1'b1;
      jump_on_carry_op: jump_taken = op.carry;
      jump_on_no_carry_op: jump_taken = !op.carry;
      jump_on_flag_op: jump_taken = op.status_flag;
      jump_on_no_flag_op: jump_taken = !op.status_flag;
      default: jump_taken = 1'b0;
    endcase
  endfunction

  // Length of an op; a zero length is treated as a single step
  function automatic logic [`PC_W-1:0] op_length(input op_req_t op);
    if (op.length == '0) begin
      op_length = {{(`PC_W-`LEN_W){1'b0}}, `LEN_ONE};
    end else begin
      op_length = {{(`PC_W-`LEN_W){1'b0}}, op.length};
    end
  endfunction

  seq_fsm_t state_ff;
  seq_fsm_t nxt_state;
  logic [`PC_W-1:0] program_counter_ff;
  logic [`PC_W-1:0] nxt_program_counter;
  logic stack_pointer_ff;
  logic nxt_stack_pointer;
  logic done_ff;
  logic sys_reset_ff;
  logic pin_drive_ff;

  logic [`SYNC_W-1:0] pin_level;
  logic reset_pin_low;
  logic poc_active;
  logic hold_reset;

  logic [`PC_W-1:0] ret_addr;
  logic ret_hi_valid;
  logic [`RET_LO_W-1:0] shared_rdata;

  logic op_fire;
  logic is_call;
  logic is_return;
  logic is_jump;
  logic stack_overflow;
  logic stack_underflow;
  logic stack_fault;
  logic [`PC_W-1:0] next_sequential;
  logic save_call;
  logic data_wr;
  logic data_rd;

  // Pin levels cross into the clock domain before anything reads them
  pin_sync u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i({power_on_clear_i, reset_pin_n_i}),
    .level_o(pin_level)
  );

  assign reset_pin_low = !pin_level[`SYNC_RST_N];
  assign poc_active = pin_level[`SYNC_POC];
  assign hold_reset = reset_pin_low || poc_active;

  // Op decode
  assign op_ready_o = (state_ff == st_run) && !hold_reset;
  assign op_fire = op_valid_i && op_ready_o;
  assign is_call = op_i.kind == subroutine_call_op;
  assign is_return = op_i.kind == subroutine_return_op;
  assign is_jump = jump_taken(op_i);
  assign next_sequential = program_counter_ff + op_length(op_i);

  // Only one return level exists: a second call or an empty return faults and resets the counter
  assign stack_overflow = is_call && (stack_pointer_ff == `SP_FULL);
  assign stack_underflow = is_return && (stack_pointer_ff == `SP_EMPTY);
  assign stack_fault = op_fire && (stack_overflow || stack_underflow);

  // Saving happens in the call's own cycle, on the same edge as the counter load
  assign save_call = op_fire && is_call && !stack_overflow;

  // A call that saves owns the shared word in its cycle; data access is dropped then
  assign data_wr = shared_data_word_i.wr && !save_call;
  assign data_rd = shared_data_word_i.rd && !save_call;

  return_address_store u_return_address_store (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .save_i(save_call),
    .save_addr_i(next_sequential),
    .data_wr_i(data_wr),
    .data_rd_i(data_rd),
    .data_wdata_i(shared_data_word_i.wdata),
    .ret_addr_o(ret_addr),
    .data_rdata_o(shared_rdata),
    .hi_valid_o(ret_hi_valid)
  );

  // Next program counter and stack pointer
  always_comb begin
    nxt_program_counter = program_counter_ff;
    nxt_stack_pointer = stack_pointer_ff;
    if (hold_reset) begin
      nxt_program_counter = `PC_RESET;
      nxt_stack_pointer = `SP_EMPTY;
    end else if (stack_fault) begin
      nxt_program_counter = `PC_RESET;
      nxt_stack_pointer = `SP_EMPTY;
    end else if (op_fire) begin
      if (is_call) begin
        nxt_program_counter = op_i.target;
        nxt_stack_pointer = `SP_FULL;
      end else if (is_return) begin
        nxt_program_counter = ret_addr;
        nxt_stack_pointer = `SP_EMPTY;
      end else if (is_jump) begin
        nxt_program_counter = op_i.target;
      end else begin
        nxt_program_counter = next_sequential;
      end
    end
  end

  // Sequencer state: held in reset, running, or one cycle of fault reset
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_held: begin
        if (!hold_reset) begin
          nxt_state = st_run;
        end
      end
      st_run: begin
        if (hold_reset) begin
          nxt_state = st_held;
        end else if (stack_fault) begin
          nxt_state = st_fault;
        end
      end
      st_fault: begin
        nxt_state = hold_reset ? st_held : st_run;
      end
      default: begin
        nxt_state = st_held;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= st_held;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      program_counter_ff <= `PC_RESET;
      stack_pointer_ff <= `SP_EMPTY;
    end else begin
      program_counter_ff <= nxt_program_counter;
      stack_pointer_ff <= nxt_stack_pointer;
    end
  end

  // Completion pulse for every op that was taken and did not fault
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= op_fire && !stack_fault;
    end
  end

  // System reset is seen outside while the reset pin or power-on clear holds or a fault fires
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sys_reset_ff <= 1'b1;
    end else begin
      sys_reset_ff <= hold_reset || stack_fault;
    end
  end

  // Power-on clear pulls the reset pin low; otherwise the pin is released
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_drive_ff <= 1'b0;
    end else begin
      pin_drive_ff <= poc_active;
    end
  end

  assign op_done_o = done_ff;
  assign system_reset_o = sys_reset_ff;
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_o = pin_drive_ff;
  assign shared_data_word_o = shared_rdata;

  assign seq_state_o.program_counter = program_counter_ff;
  assign seq_state_o.stack_pointer = stack_pointer_ff;
  assign seq_state_o.return_address = ret_addr;
  assign seq_state_o.ret_hi_valid = ret_hi_valid;

endmodule

// ===== test/program_sequencer_stack_props.sv
// Port-level checks of the program sequencer stack.
// Assumes a bind onto the top module; package compiled first.
`include "program_sequencer_cfg.svh"

module program_sequencer_stack_props
  import program_sequencer_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic reset_pin_n_i,
  input wire logic power_on_clear_i,
  input wire logic op_valid_i,
  input wire op_req_t op_i,
  input wire logic op_ready_o,
  input wire logic op_done_o,
  input wire shared_access_t shared_data_word_i,
  input wire logic [7:0] shared_data_word_o,
  input wire seq_state_t seq_state_o,
  input wire logic system_reset_o,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic tk = op_valid_i && op_ready_o;
  wire op_kind_t kd = op_i.kind;
  wire logic [9:0] pc = seq_state_o.program_counter;
  wire logic [9:0] ra = seq_state_o.return_address;
  wire logic [7:0] ra_lo = ra[7:0];
  wire logic sp = seq_state_o.stack_pointer;
  wire logic [9:0] st = (op_i.length == 0) ? 10'h001 : 10'(op_i.length);
  wire logic cl = tk && kd == subroutine_call_op;
  wire logic rt = tk && kd == subroutine_return_op;
  wire logic wr = shared_data_word_i.wr;

  // Return address is undefined until a call or a data write fills it
  logic ra_known_ff = 1'h0;
  always @(posedge ref_clk_i) begin
    if ((cl && !sp) || (wr && !cl)) begin
      ra_known_ff <= 1'h1;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence fault_s;
    pc == 10'h000 && !sp && system_reset_o && !op_ready_o;
  endsequence
  sequence pin_low_s;
    !reset_pin_n_i [*5];
  endsequence

  pc_advance_a: assert property (
    tk && kd == op_sequential |=> pc == $past(pc) + $past(st))
    else $error("pc did not advance by length");
  jump_load_a: assert property (
    tk && kd == jump_always_op |=> pc == $past(op_i.target))
    else $error("jump target not loaded");
  call_save_a: assert property (
    cl && !sp |=> pc == $past(op_i.target) && sp
      && ra == $past(pc) + $past(st))
    else $error("call did not save and load");
  ret_load_a: assert property (
    rt && sp |=> pc == $past(ra) && !sp && $stable(ra))
    else $error("return did not restore");
  stack_fault_a: assert property (
    (cl && sp) || (rt && !sp) |=> fault_s)
    else $error("stack fault not reset");
  sp_source_a: assert property ($rose(sp) |-> $past(cl))
    else $error("stack pointer rose without call");
  reset_keep_a: assert property (
    ra_known_ff && system_reset_o && !wr && !cl |=> $stable(ra))
    else $error("reset altered return address");
  done_pulse_a: assert property (
    tk && !((cl && sp) || (rt && !sp)) |=> op_done_o)
    else $error("op done pulse missing");
  shared_write_a: assert property (
    wr && !cl |=> ra_lo == $past(shared_data_word_i.wdata)
      && !seq_state_o.ret_hi_valid)
    else $error("shared write not seen");
  shared_read_a: assert property (
    shared_data_word_i.rd && !wr && !cl |=> shared_data_word_o == $past(ra_lo))
    else $error("shared read wrong");
  pin_reset_a: assert property (
    pin_low_s |-> pc == 10'h000 && !op_ready_o)
    else $error("pin reset ignored");
  poc_drive_a: assert property (
    power_on_clear_i [*5] |-> reset_pin_oe_o && !reset_pin_o)
    else $error("power-on clear not driving pin");
endmodule

// ===== test/program_sequencer_stack_tb.sv
// Self-checking bench for the program sequencer stack.
// Assumes package, header and design files are compiled first.
`include "program_sequencer_cfg.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end end

module program_sequencer_stack_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import program_sequencer_pkg::*;
  logic ref_clk_i = 0, reset_i = 1, reset_pin_n_i = 1;
  logic power_on_clear_i = 0, op_valid_i = 0;
  op_req_t op_i = '0;
  shared_access_t shared_data_word_i = '0;
  logic [7:0] shared_data_word_o;
  seq_state_t seq_state_o;
  logic op_ready_o, op_done_o, system_reset_o, reset_pin_o, reset_pin_oe_o;
  int mismatches = 0, checks_done = 0;

  program_sequencer_stack dut (.ref_clk_i, .reset_i, .reset_pin_n_i,
    .power_on_clear_i, .op_valid_i, .op_i, .op_ready_o, .op_done_o,
    .shared_data_word_i, .shared_data_word_o, .seq_state_o,
    .system_reset_o, .reset_pin_o, .reset_pin_oe_o);

  always #10 ref_clk_i = ~ref_clk_i;

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Offer one op and hold it until the edge where it is taken
  task do_op(input op_kind_t k, input logic [9:0] t, input logic c = 0,
    input logic [1:0] n = 2'h1);
    @(posedge ref_clk_i);
    op_valid_i <= 1;
    op_i <= '{k, n, t, c, ~c};
    @(negedge ref_clk_i);
    for (int i = 0; i < 20 && op_ready_o !== 1'h1; i++) @(negedge ref_clk_i);
    if (op_ready_o !== 1'h1) begin
      mismatches++;
      give_verdict();
    end
    @(posedge ref_clk_i);
    op_valid_i <= 0;
    @(negedge ref_clk_i);
  endtask

  task t_seq;
    do_op(op_sequential, 10'h3ff);
    `CHK("pc seq", 10'h001, seq_state_o.program_counter)
    `CHK("done", 1'h1, op_done_o)
    do_op(op_sequential, 10'h3ff, 1'h0, 2'h3);
    `CHK("pc len3", 10'h004, seq_state_o.program_counter)
    do_op(op_sequential, 10'h3ff, 1'h0, 2'h0);
    `CHK("pc len0", 10'h005, seq_state_o.program_counter)
  endtask

  task t_jumps;
    logic v, c;
    logic [9:0] p;
    for (int i = 1; i < 6; i++) begin
      for (int j = 0; j < 2; j++) begin
        v = (i % 2 == 0) ^ j;
        c = (i < 4) ? v : ~v;
        p = seq_state_o.program_counter + 10'h001;
        do_op(op_kind_t'(i), 10'h0a0 + 10'(i), c);
        `CHK("pc jump", (j == 0 || i == 1) ? 10'h0a0 + 10'(i) : p,
          seq_state_o.program_counter)
      end
    end
  endtask

  task t_call;
    do_op(jump_always_op, 10'h3fd);
    do_op(subroutine_call_op, 10'h155, 1'h0, 2'h2);
    `CHK("pc call", 10'h155, seq_state_o.program_counter)
    `CHK("ra call", 10'h3ff, seq_state_o.return_address)
    `CHK("sp call", 1'h1, seq_state_o.stack_pointer)
    do_op(subroutine_return_op, 10'h000);
    `CHK("pc ret", 10'h3ff, seq_state_o.program_counter)
    `CHK("sp ret", 1'h0, seq_state_o.stack_pointer)
    `CHK("ra ret", 10'h3ff, seq_state_o.return_address)
  endtask

  task t_fault;
    do_op(jump_always_op, 10'h040);
    do_op(subroutine_call_op, 10'h0c3);
    do_op(subroutine_call_op, 10'h2aa);
    `CHK("pc ovf", 10'h000, seq_state_o.program_counter)
    `CHK("rst ovf", 1'h1, system_reset_o)
    `CHK("ra ovf", 10'h041, seq_state_o.return_address)
    do_op(jump_always_op, 10'h111);
    do_op(subroutine_return_op, 10'h000);
    `CHK("pc unf", 10'h000, seq_state_o.program_counter)
    `CHK("sp unf", 1'h0, seq_state_o.stack_pointer)
  endtask

  task t_shared;
    @(posedge ref_clk_i);
    shared_data_word_i <= '{1'h0, 1'h1, 8'h5a};
    @(posedge ref_clk_i);
    shared_data_word_i <= '{1'h1, 1'h0, 8'h00};
    @(posedge ref_clk_i);
    shared_data_word_i <= '0;
    @(negedge ref_clk_i);
    `CHK("ra lo", 8'h5a, seq_state_o.return_address[7:0])
    `CHK("hi ok", 1'h0, seq_state_o.ret_hi_valid)
    `CHK("rdata", 8'h5a, shared_data_word_o)
  endtask

  task t_pin;
    do_op(jump_always_op, 10'h2c2);
    @(posedge ref_clk_i);
    reset_pin_n_i <= 0;
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    `CHK("pc pin", 10'h000, seq_state_o.program_counter)
    `CHK("rdy pin", 1'h0, op_ready_o)
    `CHK("srst pin", 1'h1, system_reset_o)
    `CHK("oe pin", 1'h0, reset_pin_oe_o)
    @(posedge ref_clk_i);
    reset_pin_n_i <= 1;
    do_op(jump_always_op, 10'h077);
    `CHK("ra pin", 8'h5a, seq_state_o.return_address[7:0])
    @(posedge ref_clk_i);
    power_on_clear_i <= 1;
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    `CHK("oe poc", 1'h1, reset_pin_oe_o)
    `CHK("pin poc", 1'h0, reset_pin_o)
    @(posedge ref_clk_i);
    power_on_clear_i <= 0;
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    `CHK("oe off", 1'h0, reset_pin_oe_o)
    @(posedge ref_clk_i);
    reset_i <= 1;
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 0;
    @(negedge ref_clk_i);
    `CHK("ra rst", 10'h05a, seq_state_o.return_address)
    `CHK("sp rst2", 1'h0, seq_state_o.stack_pointer)
    do_op(jump_always_op, 10'h123);
    `CHK("pc rerun", 10'h123, seq_state_o.program_counter)
  endtask

  initial begin
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 0;
    @(negedge ref_clk_i);
    `CHK("pc rst", 10'h000, seq_state_o.program_counter)
    `CHK("sp rst", 1'h0, seq_state_o.stack_pointer)
    t_seq();
    t_jumps();
    t_call();
    t_fault();
    t_shared();
    t_pin();
    give_verdict();
  end
endmodule

bind program_sequencer_stack program_sequencer_stack_props props (
  .ref_clk_i, .reset_i, .reset_pin_n_i, .power_on_clear_i, .op_valid_i,
  .op_i, .op_ready_o, .op_done_o, .shared_data_word_i, .shared_data_word_o,
  .seq_state_o, .system_reset_o, .reset_pin_o, .reset_pin_oe_o);
